// File: design/nibble_mem.sv
// Purpose: nibble store for the RAM and the segment latches
// Assumes: one port; write and read share the address
// Notes:   read data comes out of a register one edge after the address
`timescale 1ns/1ns
module nibble_mem #(
    parameter int DEPTH = 80,
    parameter int WIDTH = 4
) (
    input  wire logic                     clk_i,
    input  wire logic [$clog2(DEPTH)-1:0] addr_i,
    input  wire logic                     we_i,
    input  wire logic [WIDTH-1:0]         wdata_i,
    output logic      [WIDTH-1:0]         rdata_o
);
    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad
            $error("nibble_mem: depth or width too small");
        end
    endgenerate

    logic [WIDTH-1:0] store_q [DEPTH];

    // contents are not reset, as on the real part
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            store_q[addr_i] <= wdata_i;
        end
        rdata_o <= store_q[addr_i];
    end
endmodule : nibble_mem

// File: design/periph_defs.svh
// Purpose: offsets, field positions and reset values of the peripheral map
// Assumes: register indexes; the bus byte address is four times the index
// Notes:   included by the package and by the register block
`ifndef PERIPH_DEFS_SVH
`define PERIPH_DEFS_SVH

`define ADR_W        10
`define IDX_W        8
`define NIB_W        4

// memory window: nibble RAM, then segment latches
`define OFS_RAM_LO   8'h00
`define OFS_RAM_HI   8'h3F
`define OFS_SEG_LO   8'h40
`define OFS_SEG_HI   8'h4F
`define MEM_DEPTH    80

`define OFS_PA       8'h50
`define OFS_PB_DIR   8'h51
`define OFS_PB_DATA  8'h52
`define OFS_COMP     8'h53
`define OFS_CNT_C1   8'h5B
`define OFS_CNT_C2   8'h5C
`define OFS_CNT_L    8'h5D
`define OFS_CNT_M    8'h5E
`define OFS_CNT_H    8'h5F
`define OFS_MS_C1    8'h60
`define OFS_MS_C2    8'h61
`define OFS_MS_L     8'h62
`define OFS_MS_M     8'h63
`define OFS_MS_H     8'h64
`define OFS_MASK1    8'h65
`define OFS_MASK2    8'h66
`define OFS_MASK3    8'h67
`define OFS_IRQ1     8'h68
`define OFS_IRQ2     8'h69
`define OFS_LCD1     8'h71
`define OFS_LCD2     8'h72

// second display control: blank, off, four-phase set; bias bit by POR only
`define LCD2_RESET   4'hE
`define LCD2_EXT     0
`define LCD2_MUX4    1
`define LCD2_OFF     2
`define LCD2_BLANK   3

`endif

// File: design/periph_pkg.sv
// Purpose: types shared by the peripheral register block
// Assumes: periph_defs.svh gives widths
// Notes:   every state of the block but the nibble memory lives in state_type
package periph_pkg;
`include "periph_defs.svh"

    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [`ADR_W-1:0] adr;
        logic [3:0]        sel;
        logic [31:0]       dat;
    } wb_req_type;

    typedef struct packed {
        logic [3:0] pb_dir;
        logic [3:0] pb_data;
        logic [1:0] comp_ctl;
        logic [3:0] cnt_ctl1;
        logic [3:1] cnt_ctl2;
        logic [9:0] reload;
        logic [1:0] width_sel;
        logic [3:1] ms_ctl1;
        logic [3:1] ms_ctl2;
        logic [3:0] mask1;
        logic [3:0] mask2;
        logic [3:0] mask3;
        logic       cnt_load;
        logic       ms_clear;
    } ctrl_type;

    typedef struct packed {
        logic       pend;
        logic       ack;
        logic [3:0] dat;
        logic [1:0] lcd1;
        logic [3:0] lcd2;
        logic [3:0] irq1;
        logic [3:0] irq2;
        ctrl_type   ctrl;
        logic       pump_clk;
        logic       pwr_down;
        logic       irq_req;
    } state_type;

endpackage : periph_pkg

// File: design/peripheral_register_map.sv
// Purpose: peripheral register map of a 4-bit controller, classic Wishbone
// Assumes: 10 MHz clk_i, synchronous resets, inputs synchronous to clk_i
// Notes:   nibble data in bits 3:0 of the word, upper bits read zero;
//          ack comes two edges after the request is seen
`timescale 1ns/1ns
`include "periph_defs.svh"

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - clock select picks 512/256/128/64 Hz tap
// - first display control: select bits 1:0, reset 0
// - blank bit resets one, turns segments off
// - off bit resets one, stops voltage multiplier
// - mux bit resets one; clear drops fourth backplane
// - external bias bit cleared by power-on only
// - external bias disables regulator, floats bias pins
// - reset values apply at power-on and system reset
// - 0x50 reads live input port levels
// - 0x51 direction bits, reset zero means inputs
// - 0x52 writes latches, reads pin levels
// - 0x53 comparator select, enable, live result
// - 0x5B counter frequency and direction, reset zero
// - 0x5C load pulse, compare, event, start bits
// - 0x5D-0x5F read count, write reload and width
// - 0x60 bit0 clears millisecond counter, reads zero
// - 0x61 bit0 one-second flag, three control bits
// - 0x62-0x64 read BCD count, writes ignored
// - masks 0x65-0x67 active low, reset zero
// - status reads pending, write one clears
// - 0x69 comparator, blink, 32/8, 1 Hz flags
module peripheral_register_map
    import periph_pkg::*;
#(
    parameter int MEM_DEPTH = `MEM_DEPTH
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        por_i,
    input  wire wb_req_type  wb_i,
    output logic             ack_o,
    output logic [31:0]      dat_o,
    input  wire logic [3:0]  pa_i,
    input  wire logic [3:0]  pb_i,
    output logic      [3:0]  pb_o,
    output logic      [3:0]  pb_oe_o,
    input  wire logic        comp_result_i,
    input  wire logic [9:0]  count_i,
    input  wire logic [11:0] ms_count_i,
    input  wire logic        one_second_i,
    input  wire logic [7:0]  irq_event_i,
    input  wire logic [3:0]  pump_taps_i,
    output ctrl_type         ctrl_o,
    output logic             segments_off_o,
    output logic             display_power_down_o,
    output logic             fourth_backplane_off_o,
    output logic             bias_hiz_o,
    output logic             pump_clock_o,
    output logic             irq_req_o
);
    generate
        if (MEM_DEPTH != `MEM_DEPTH) begin : g_bad
            $error("peripheral_register_map: memory depth must be 80");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic is_mem(input logic [`IDX_W-1:0] idx);
        is_mem = (idx <= `OFS_SEG_HI);
    endfunction : is_mem

    state_type                    q;
    state_type                    d;
    logic [`IDX_W-1:0]            idx;
    logic                         req;
    logic                         wr;
    logic [3:0]                   wdat;
    logic [3:0]                   mem_rdata;
    logic                         mem_we;
    logic [$clog2(MEM_DEPTH)-1:0] mem_addr;

    assign idx  = wb_i.adr[`ADR_W-1:2];
    assign req  = wb_i.cyc & wb_i.stb;
    assign wr   = wb_i.we & wb_i.sel[0];
    assign wdat = wb_i.dat[3:0];

    // memory is read at the first edge and written at the answer edge
    assign mem_addr = is_mem(idx) ? idx[$clog2(MEM_DEPTH)-1:0] : '0;
    assign mem_we   = q.pend & wr & is_mem(idx);

    nibble_mem #(
        .DEPTH (MEM_DEPTH),
        .WIDTH (`NIB_W)
    ) u_mem (
        .clk_i   (clk_i),
        .addr_i  (mem_addr),
        .we_i    (mem_we),
        .wdata_i (wdat),
        .rdata_o (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [3:0] rd;
        logic [3:0] clr1;
        logic [3:0] clr2;
        rd   = 4'h0;
        clr1 = 4'h0;
        clr2 = 4'h0;
        d    = q;
        d.ack = 1'b0;
        d.ctrl.cnt_load = 1'b0;
        d.ctrl.ms_clear = 1'b0;

        if (req && !q.pend && !q.ack) begin
            d.pend = 1'b1;
        end

        if (q.pend) begin
            d.pend = 1'b0;
            d.ack  = 1'b1;
            case (idx)
                `OFS_PA:      rd = pa_i;
                `OFS_PB_DIR:  rd = q.ctrl.pb_dir;
                `OFS_PB_DATA: rd = pb_i;
                `OFS_COMP:    rd = {1'b0, comp_result_i,
                                    q.ctrl.comp_ctl};
                `OFS_CNT_C1:  rd = q.ctrl.cnt_ctl1;
                `OFS_CNT_C2:  rd = {q.ctrl.cnt_ctl2, 1'b0};
                `OFS_CNT_L:   rd = count_i[3:0];
                `OFS_CNT_M:   rd = count_i[7:4];
                `OFS_CNT_H:   rd = {q.ctrl.width_sel, count_i[9:8]};
                `OFS_MS_C1:   rd = {q.ctrl.ms_ctl1, 1'b0};
                `OFS_MS_C2:   rd = {q.ctrl.ms_ctl2, one_second_i};
                `OFS_MS_L:    rd = ms_count_i[3:0];
                `OFS_MS_M:    rd = ms_count_i[7:4];
                `OFS_MS_H:    rd = ms_count_i[11:8];
                `OFS_MASK1:   rd = q.ctrl.mask1;
                `OFS_MASK2:   rd = q.ctrl.mask2;
                `OFS_MASK3:   rd = q.ctrl.mask3;
                `OFS_IRQ1:    rd = q.irq1;
                `OFS_IRQ2:    rd = q.irq2;
                `OFS_LCD1:    rd = {2'h0, q.lcd1};
                `OFS_LCD2:    rd = q.lcd2;
                default:      rd = is_mem(idx) ? mem_rdata : 4'h0;
            endcase
            d.dat = wb_i.we ? 4'h0 : rd;

            if (wr) begin
                case (idx)
                    `OFS_PB_DIR:  d.ctrl.pb_dir = wdat;
                    `OFS_PB_DATA: d.ctrl.pb_data = wdat;
                    `OFS_COMP:    d.ctrl.comp_ctl = wdat[1:0];
                    `OFS_CNT_C1:  d.ctrl.cnt_ctl1 = wdat;
                    `OFS_CNT_C2: begin
                        d.ctrl.cnt_ctl2 = wdat[3:1];
                        d.ctrl.cnt_load = wdat[0];
                    end
                    `OFS_CNT_L:   d.ctrl.reload[3:0] = wdat;
                    `OFS_CNT_M:   d.ctrl.reload[7:4] = wdat;
                    `OFS_CNT_H: begin
                        d.ctrl.reload[9:8] = wdat[1:0];
                        d.ctrl.width_sel = wdat[3:2];
                    end
                    `OFS_MS_C1: begin
                        d.ctrl.ms_ctl1  = wdat[3:1];
                        d.ctrl.ms_clear = wdat[0];
                    end
                    `OFS_MS_C2:   d.ctrl.ms_ctl2 = wdat[3:1];
                    `OFS_MASK1:   d.ctrl.mask1 = wdat;
                    `OFS_MASK2:   d.ctrl.mask2 = wdat;
                    `OFS_MASK3:   d.ctrl.mask3 = wdat;
                    `OFS_IRQ1:    clr1 = wdat;
                    `OFS_IRQ2:    clr2 = wdat;
                    `OFS_LCD1:    d.lcd1 = wdat[1:0];
                    `OFS_LCD2:    d.lcd2 = wdat;
                    // read-only count nibbles and port A drop the write
                    default:      d.lcd1 = q.lcd1;
                endcase
            end
        end

        // a new event in the clearing cycle keeps its flag
        d.irq1 = (q.irq1 & ~clr1) | irq_event_i[3:0];
        d.irq2 = (q.irq2 & ~clr2) | irq_event_i[7:4];

        if (rst_i || por_i) begin
            d       = '0;
            d.lcd2  = `LCD2_RESET;
            // system reset alone keeps the bias source choice
            d.lcd2[`LCD2_EXT] = por_i ? 1'b0 : q.lcd2[`LCD2_EXT];
        end

        // outputs derived here so that each leaves from a flip-flop
        d.pwr_down = d.lcd2[`LCD2_OFF] | d.lcd2[`LCD2_EXT];
        d.pump_clk = pump_taps_i[d.lcd1] & ~d.pwr_down;
        // a mask bit of zero blocks its source
        d.irq_req  = |({d.irq2, d.irq1}
                       & {d.ctrl.mask2, d.ctrl.mask1});
    end

    always_ff @(posedge clk_i) begin
        q <= d;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign ack_o                  = q.ack;
    assign dat_o                  = {28'h000_0000, q.dat};
    assign pb_o                   = q.ctrl.pb_data;
    assign pb_oe_o                = q.ctrl.pb_dir;
    assign ctrl_o                 = q.ctrl;
    assign segments_off_o         = q.lcd2[`LCD2_BLANK];
    assign display_power_down_o   = q.pwr_down;
    assign fourth_backplane_off_o = ~q.lcd2[`LCD2_MUX4];
    assign bias_hiz_o             = q.lcd2[`LCD2_EXT];
    assign pump_clock_o           = q.pump_clk;
    assign irq_req_o              = q.irq_req;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || por_i);

    bus_answer_a: assert property (
        req && !ack_o && !q.pend |=> q.pend ##1 ack_o ##1 !ack_o)
        else $error("bus answer not two edges after request");

    port_a_read_a: assert property (
        ack_o && !wb_i.we && idx == `OFS_PA |-> dat_o[3:0] == $past(pa_i))
        else $error("port A read does not show pin levels");

    pin_read_a: assert property (
        ack_o && !wb_i.we && idx == `OFS_PB_DATA
        |-> dat_o[3:0] == $past(pb_i))
        else $error("port B read does not show pin levels");

    clear_pulse_a: assert property (
        q.pend && wr && idx == `OFS_MS_C1 && wdat[0]
        |=> ctrl_o.ms_clear ##1 !ctrl_o.ms_clear)
        else $error("millisecond clear not a single pulse");

    load_pulse_a: assert property (
        ctrl_o.cnt_load |=> !ctrl_o.cnt_load)
        else $error("counter load longer than one cycle");

    flag_set_a: assert property (
        irq_event_i[0] |=> q.irq1[0] && rd_zero_gate(q.irq1))
        else $error("port A event lost");

    w1c_clear_a: assert property (
        q.pend && wr && idx == `OFS_IRQ2 && wdat[2] && !irq_event_i[6]
        |=> !q.irq2[2])
        else $error("status bit not cleared by a written one");

    pump_stop_a: assert property (
        q.lcd2[`LCD2_OFF] || q.lcd2[`LCD2_EXT] |-> !pump_clock_o)
        else $error("pump clock runs while multiplier is off");

    pump_tap_a: assert property (
        !display_power_down_o && $stable(q.lcd2) && $stable(q.lcd1)
        |-> pump_clock_o == $past(pump_taps_i[q.lcd1]))
        else $error("pump clock from wrong tap");

    mask_gate_a: assert property (
        irq_req_o |-> |({q.irq2, q.irq1} & {q.ctrl.mask2, q.ctrl.mask1}))
        else $error("request raised through a zero mask");

    bias_keep_a: assert property (
        @(posedge clk_i) disable iff (por_i)
        rst_i |=> bias_hiz_o == $past(bias_hiz_o))
        else $error("system reset changed the bias source bit");

    blank_reset_a: assert property (
        @(posedge clk_i) disable iff (1'b0)
        rst_i || por_i |=> segments_off_o && display_power_down_o
                          && !fourth_backplane_off_o && pb_oe_o == 4'h0)
        else $error("display control reset values wrong");

    function automatic logic rd_zero_gate(input logic [3:0] v);
        rd_zero_gate = (v != 4'h0);
    endfunction : rd_zero_gate

endmodule : peripheral_register_map

// File: dv/tb_peripheral_register_map.sv
// Purpose: register-level test of the peripheral map over Wishbone
// Assumes: one nibble per access; reset values after por are known
// Notes:   the display bias bit is checked across both reset kinds
`timescale 1ns/1ns
module tb_peripheral_register_map;
    import periph_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1;
    logic        go = 1'b0, we = 1'b0, done, ack;
    logic [7:0]  idx = 8'h00, irq_ev = 8'h00;
    logic [3:0]  wd = 4'h0, pa = 4'h0, pb = 4'h0, taps = 4'h0;
    logic [3:0]  pb_o, pb_oe;
    logic [31:0] rdat, dat, rq;
    logic [9:0]  count = 10'h000;
    logic [11:0] ms = 12'h000;
    logic        comp = 1'b0, one_sec = 1'b0;
    logic        seg_off, pdown, bp_off, hiz, pclk, irq_req;
    wb_req_type  wb;
    ctrl_type    ctrl;
    int          err_total = 0, cmp_count = 0;
    initial forever #50 clk_i = ~clk_i;
    wb_master_model cpu (.clk_i(clk_i), .rst_i(rst_i | por_i), .go_i(go),
        .we_i(we), .idx_i(idx), .wdat_i(wd), .ack_i(ack), .dat_i(dat),
        .wb_o(wb), .done_o(done), .rdat_o(rdat));
    peripheral_register_map DUT (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
        .wb_i(wb), .ack_o(ack), .dat_o(dat), .pa_i(pa), .pb_i(pb),
        .pb_o(pb_o), .pb_oe_o(pb_oe), .comp_result_i(comp), .count_i(count),
        .ms_count_i(ms), .one_second_i(one_sec), .irq_event_i(irq_ev),
        .pump_taps_i(taps), .ctrl_o(ctrl), .segments_off_o(seg_off),
        .display_power_down_o(pdown), .fourth_backplane_off_o(bp_off),
        .bias_hiz_o(hiz), .pump_clock_o(pclk), .irq_req_o(irq_req));
////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] i,
                        input logic [3:0] d);
        int n;
        go <= 1'b1;
        we <= w;
        idx <= i;
        wd <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (done !== 1'b1 && n < 40);
        rq = rdat;
        go <= 1'b0;
        @(posedge clk_i);
        // a hung bus ends the run here
        if (n >= 40) begin
            err_total++;
            complete_run();
        end
    endtask : xfer
    task automatic wr(input logic [7:0] i, input logic [3:0] d);
        xfer(1'b1, i, d);
    endtask : wr
    task automatic rd(input logic [7:0] i, input logic [3:0] e);
        xfer(1'b0, i, 4'h0);
        chk(rq, {28'h000_0000, e});
    endtask : rd
    task automatic pulse_rst(input logic p);
        rst_i <= 1'b1;
        por_i <= p;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
    endtask : pulse_rst
////////////////////////////////////////////////////////////////////////////
    logic [7:0] zero_regs [12] = '{8'h51, 8'h53, 8'h5B, 8'h5C, 8'h5D, 8'h60,
        8'h61, 8'h65, 8'h66, 8'h67, 8'h68, 8'h69};
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        foreach (zero_regs[k]) begin
            rd(zero_regs[k], 4'h0);
        end
        rd(8'h71, 4'h0);
        rd(8'h72, 4'hE);
        chk({pb_oe, seg_off, pdown, bp_off}, {4'h0, 3'b110});
        $display("test reset_values done");
        wr(8'h51, 4'h9);
        rd(8'h51, 4'h9);
        chk(pb_oe, 4'h9);
        wr(8'h5B, 4'hF);
        rd(8'h5B, 4'hF);
        chk(ctrl.cnt_ctl1, 4'hF);
        wr(8'h5C, 4'hF);
        rd(8'h5C, 4'hE);
        chk(ctrl.cnt_ctl2, 3'h7);
        comp <= 1'b1;
        wr(8'h53, 4'hF);
        rd(8'h53, 4'h7);
        chk(ctrl.comp_ctl, 2'h3);
        wr(8'h60, 4'hF);
        rd(8'h60, 4'hE);
        wr(8'h61, 4'hF);
        rd(8'h61, 4'hE);
        one_sec <= 1'b1;
        rd(8'h61, 4'hF);
        wr(8'h71, 4'hF);
        rd(8'h71, 4'h3);
        wr(8'h67, 4'h5);
        rd(8'h67, 4'h5);
        chk(ctrl.mask3, 4'h5);
        wr(8'h00, 4'h5);
        wr(8'h3F, 4'hA);
        wr(8'h4F, 4'h6);
        rd(8'h00, 4'h5);
        rd(8'h3F, 4'hA);
        rd(8'h4F, 4'h6);
        $display("test read_write done");
        pa <= 4'hA;
        pb <= 4'h3;
        count <= 10'h2C5;
        ms <= 12'h987;
        wr(8'h50, 4'h5);
        rd(8'h50, 4'hA);
        wr(8'h52, 4'hC);
        rd(8'h52, 4'h3);
        chk(pb_o, 4'hC);
        wr(8'h5D, 4'h9);
        wr(8'h5E, 4'h6);
        wr(8'h5F, 4'hC);
        chk({ctrl.width_sel, ctrl.reload}, 12'hC69);
        rd(8'h5D, 4'h5);
        rd(8'h5E, 4'hC);
        rd(8'h5F, 4'hE);
        wr(8'h62, 4'h0);
        wr(8'h63, 4'h0);
        wr(8'h64, 4'h0);
        rd(8'h62, 4'h7);
        rd(8'h63, 4'h8);
        rd(8'h64, 4'h9);
        $display("test live_inputs done");
        wr(8'h72, 4'h2);
        for (int s = 0; s < 4; s++) begin
            wr(8'h71, s[3:0]);
            taps <= 4'h1 << s;
            repeat (3) @(posedge clk_i);
            chk(pclk, 1'b1);
            taps <= ~(4'h1 << s);
            repeat (3) @(posedge clk_i);
            chk(pclk, 1'b0);
        end
        // the four-phase bit is clear in the first three writes, so the fourth backplane is off
        wr(8'h72, 4'h8);
        chk({seg_off, pdown, bp_off, hiz}, 4'hA);
        wr(8'h72, 4'h4);
        chk({seg_off, pdown, bp_off, hiz}, 4'h6);
        wr(8'h72, 4'h0);
        chk({seg_off, pdown, bp_off, hiz}, 4'h2);
        wr(8'h72, 4'h3);
        chk({seg_off, pdown, bp_off, hiz}, 4'h5);
        // system reset keeps the bias bit, power-on clears it
        pulse_rst(1'b0);
        rd(8'h72, 4'hF);
        chk(hiz, 1'b1);
        rd(8'h51, 4'h0);
        rd(8'h5B, 4'h0);
        pulse_rst(1'b1);
        rd(8'h72, 4'hE);
        chk(hiz, 1'b0);
        $display("test display_control done");
        irq_ev <= 8'hFF;
        @(posedge clk_i);
        irq_ev <= 8'h00;
        rd(8'h68, 4'hF);
        rd(8'h69, 4'hF);
        chk(irq_req, 1'b0);
        wr(8'h65, 4'h1);
        chk(irq_req, 1'b1);
        wr(8'h68, 4'h5);
        rd(8'h68, 4'hA);
        chk(irq_req, 1'b0);
        wr(8'h69, 4'h0);
        rd(8'h69, 4'hF);
        wr(8'h66, 4'h8);
        chk(irq_req, 1'b1);
        wr(8'h69, 4'hC);
        rd(8'h69, 4'h3);
        chk(irq_req, 1'b0);
        $display("test interrupt_status done");
        complete_run();
    end
endmodule : tb_peripheral_register_map

// File: dv/wb_master_model.sv
// Purpose: processor-side bus master issuing classic Wishbone cycles
// Assumes: go_i held until done_o seen; one nibble per word on bits 3:0
// Notes:   released address and data show inverted values, not stale ones
`timescale 1ns/1ns
module wb_master_model
    import periph_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        go_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  idx_i,
    input  wire logic [3:0]  wdat_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output wb_req_type       wb_o,
    output logic             done_o,
    output logic [31:0]      rdat_o
);
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            wb_o   <= '0;
            rdat_o <= '0;
        end else if (wb_o.cyc && ack_i) begin
            // take data only at the ack edge, then leave the bus
            rdat_o   <= dat_i;
            done_o   <= 1'b1;
            wb_o.cyc <= 1'b0;
            wb_o.stb <= 1'b0;
            wb_o.we  <= ~wb_o.we;
            wb_o.adr <= ~wb_o.adr;
            wb_o.dat <= ~wb_o.dat;
        end else if (!wb_o.cyc && go_i && !done_o) begin
            wb_o.cyc <= 1'b1;
            wb_o.stb <= 1'b1;
            wb_o.we  <= we_i;
            wb_o.adr <= {idx_i, 2'b00};
            wb_o.sel <= 4'h1;
            wb_o.dat <= {28'h000_0000, wdat_i};
        end
    end
endmodule : wb_master_model
